// *** design/gst_defs.svh ***
`ifndef GST_DEFS_SVH
`define GST_DEFS_SVH

// Clock source select codes.
`define GST_CS_INSTR 2'h0
`define GST_CS_SYS 2'h1
`define GST_CS_EXT 2'h2

// System clock select code that picks the secondary oscillator.
`define GST_SCS_SEC_OSC 2'h1

// Gate source select codes.
`define GST_GSS_PIN 2'h0
`define GST_GSS_MATCH 2'h1
`define GST_GSS_CMP1 2'h2
`define GST_GSS_CMP2 2'h3

// Prescale select codes and the matching low-bit masks of the prescale counter.
`define GST_PS_DIV1 2'h0
`define GST_PS_DIV2 2'h1
`define GST_PS_DIV4 2'h2
`define GST_PS_DIV8 2'h3
`define GST_MASK_DIV1 3'h0
`define GST_MASK_DIV2 3'h1
`define GST_MASK_DIV4 3'h3
`define GST_MASK_DIV8 3'h7

// Reset values and limits.
`define GST_CNT_RESET 16'h0000
`define GST_CNT_MAX 16'hffff
`define GST_CNT_ONE 16'h0001
`define GST_PRE_RESET 3'h0
`define GST_PRE_ONE 3'h1
`define GST_DIV_RESET 2'h0
`define GST_DIV_ONE 2'h1
`define GST_DIV_LAST 2'h3

`endif

// *** design/gst_pkg.sv ***
package gst_pkg;

  // Static configuration of one timer instance, as software set it.
  typedef struct packed {
    logic timer_on;           // Master on bit.
    logic gate_enable;        // Counting follows the gate when set.
    logic gate_polarity;      // Gate level that lets the counter run.
    logic [1:0] gate_select;  // Gate source choice.
    logic [1:0] clock_select; // Clock source choice.
    logic sec_osc_enable;     // Own request for the secondary oscillator.
    logic sync_disable;       // Bypass the count input synchronizer.
    logic [1:0] prescale_select; // Divide by 1, 2, 4 or 8.
  } gst_cfg_t;

  // Readiness of the external count input after a write or a disable.
  typedef enum logic [1:0] {
    GST_WAIT_LOW = 2'b01,
    GST_READY = 2'b10
  } gst_arm_t;

endpackage

// *** design/gst_timer.sv ***
// Operation
// R1: 16-bit counter, byte writes update live count.
// R2: Instruction clock gives one count per cycle.
// R3: On bit and gate enable decide counting.
// R4: Clock select picks system, instruction, pin, oscillator.
// R5: One secondary oscillator shared by three instances.
// R6: System clock gives four counts per instruction.
// R7: External pin counts on rising edges.
// R8: Falling edge needed before first counted rise.
// R9: Prescaler divides by 1, 2, 4 or 8.
// R10: Prescaler hidden, cleared on any byte write.
// R11: Oscillator enabled by enables, go bit, select.
// R12: Running oscillator keeps going during sleep.
// R13: Software waits for oscillator start before enabling.
// R14: Sync disable bypasses the count input synchronizer.
// R15: Async external counting continues and wakes in sleep.
// R16: Mode switch may lose or add one count.
// R17: Gate accepts pin, match or comparator sources.
// R18: Gate level equal to polarity lets counting run.
// R19: Wrap to zero sets sticky overflow flag.
`include "gst_defs.svh"

module gst_timer (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration.
  input wire gst_pkg::gst_cfg_t cfg,
  input wire logic [1:0] other_sec_osc_enable,
  input wire logic sec_osc_go,
  input wire logic [1:0] system_clock_select,
  input wire logic sleep,
  // Counter byte writes.
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wr_data,
  // Overflow flag clear strobe.
  input wire logic overflow_clear,
  // Pins and gate sources.
  input wire logic count_input_pin,
  input wire logic sec_osc_in_pin,
  input wire logic gate_pin,
  input wire logic gate_match,
  input wire logic gate_cmp1,
  input wire logic gate_cmp2,
  // Counter value and status.
  output logic [7:0] count_high_byte,
  output logic [7:0] count_low_byte,
  output logic overflow_flag,
  output logic wake_pulse,
  output logic sec_osc_running,
  output logic sec_osc_out_pin
);
  import gst_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State.

  logic [15:0] cnt;        // Live counter.
  logic [15:0] next_cnt;
  logic [2:0] pre;         // Hidden prescale counter.
  logic [2:0] next_pre;
  logic [1:0] instr_div;   // Divide by four for the instruction clock.
  logic [1:0] next_instr_div;
  logic pin_s1;            // First synchronizer stage, read only by pin_s2.
  logic pin_s2;            // Second synchronizer stage.
  logic pin_direct;        // Unsynchronized sample for the bypass path.
  logic osc_q;             // Sample of the oscillator input.
  logic ext_prev;          // Previous external level for edge detection.
  logic next_ext_prev;
  gst_arm_t arm;           // Low level seen since the last write or disable.
  gst_arm_t next_arm;
  logic next_overflow_flag;
  logic next_wake_pulse;
  logic next_sec_osc_running;
  logic next_sec_osc_out_pin;

  // Decoded combinational terms.
  logic wr_any;            // Either byte written this cycle.
  logic ext_level;         // Selected external count level.
  logic src_tick;          // One event of the selected clock source.
  logic [2:0] pre_mask;    // Prescale counter bits that must be all ones.
  logic pre_tick;          // Clock event after the prescaler.
  logic gate_level;        // Selected gate source level.
  logic count_en;          // On bit and gate allow counting.
  logic sleep_ok;          // Source keeps running in the present power state.
  logic inc;               // Counter advances this cycle unless a byte is written.
  logic wrap;              // Counter wraps from all ones to zero.

  //////////////////////////////////////////////////////////////////////////////
  // Input sampling.

  // The async bypass reads its own flop, so the synchronizer's first stage
  // stays private to the second stage.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_direct <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      pin_s1 <= count_input_pin;
      pin_s2 <= pin_s1;
      pin_direct <= count_input_pin;
      osc_q <= sec_osc_in_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Secondary oscillator.

  // The amplifier runs whenever any requester wants it; sleep does not stop it.
  always_comb begin
    next_sec_osc_running = cfg.sec_osc_enable | (|other_sec_osc_enable) | sec_osc_go // R5
      | (system_clock_select == `GST_SCS_SEC_OSC); // R11 R12
    // The amplifier output inverts the crystal input only while running.
    next_sec_osc_out_pin = next_sec_osc_running & ~osc_q;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sec_osc_running <= 1'b0;
      sec_osc_out_pin <= 1'b0;
    end else begin
      sec_osc_running <= next_sec_osc_running;
      sec_osc_out_pin <= next_sec_osc_out_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock source, gate and prescaler.

  always_comb begin
    wr_any = wr_high | wr_low;
    next_instr_div = instr_div + `GST_DIV_ONE;
    // The oscillator takes over the external path when this instance enables it.
    if (cfg.sec_osc_enable) begin
      ext_level = osc_q; // R4
    end else if (cfg.sync_disable) begin
      ext_level = pin_direct; // R14
    end else begin
      ext_level = pin_s2;
    end
    // Switching the sync path may present a spurious or missed edge once.
    next_ext_prev = ext_level; // R16
    // Clock source selection; the unused code gives no events.
    if (cfg.clock_select == `GST_CS_SYS) begin
      src_tick = 1'b1; // R4 R6
    end else if (cfg.clock_select == `GST_CS_INSTR) begin
      src_tick = (instr_div == `GST_DIV_LAST); // R2
    end else if (cfg.clock_select == `GST_CS_EXT) begin
      src_tick = ext_level & ~ext_prev & (arm == GST_READY); // R7 R8
    end else begin
      src_tick = 1'b0;
    end
    // Gate source selection; all sources are taken at full clock rate.
    if (cfg.gate_select == `GST_GSS_PIN) begin
      gate_level = gate_pin; // R17
    end else if (cfg.gate_select == `GST_GSS_MATCH) begin
      gate_level = gate_match;
    end else if (cfg.gate_select == `GST_GSS_CMP1) begin
      gate_level = gate_cmp1; // R17
    end else begin
      gate_level = gate_cmp2;
    end
    count_en = cfg.timer_on & (~cfg.gate_enable | (gate_level == cfg.gate_polarity)); // R3 R18
    // Only the unsynchronized external path has a clock while asleep.
    sleep_ok = ~sleep | ((cfg.clock_select == `GST_CS_EXT) & cfg.sync_disable); // R15
    if (cfg.prescale_select == `GST_PS_DIV1) begin
      pre_mask = `GST_MASK_DIV1; // R9
    end else if (cfg.prescale_select == `GST_PS_DIV2) begin
      pre_mask = `GST_MASK_DIV2;
    end else if (cfg.prescale_select == `GST_PS_DIV4) begin
      pre_mask = `GST_MASK_DIV4;
    end else begin
      pre_mask = `GST_MASK_DIV8;
    end
    // The prescaler only sees events that the enable and gate let through.
    pre_tick = src_tick & count_en & sleep_ok & ((pre & pre_mask) == pre_mask); // R9
    if (wr_any) begin
      next_pre = `GST_PRE_RESET; // R10
    end else if (src_tick & count_en & sleep_ok) begin
      next_pre = pre + `GST_PRE_ONE;
    end else begin
      next_pre = pre;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      instr_div <= `GST_DIV_RESET;
      pre <= `GST_PRE_RESET;
      ext_prev <= 1'b0;
    end else begin
      instr_div <= next_instr_div;
      pre <= next_pre;
      ext_prev <= next_ext_prev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Falling edge arming of the count input.

  // A write or a disable forgets any low level seen, so the next rise only
  // counts after the input has been low again.
  always_comb begin
    next_arm = arm;
    case (arm)
      GST_WAIT_LOW: begin
        if (!wr_any && cfg.timer_on && !ext_level) begin
          next_arm = GST_READY; // R8
        end
      end
      GST_READY: begin
        if (wr_any || !cfg.timer_on) begin
          next_arm = GST_WAIT_LOW; // R8
        end
      end
      default: begin
        next_arm = GST_WAIT_LOW;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      arm <= GST_WAIT_LOW;
    end else begin
      arm <= next_arm;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter and overflow.

  // A byte write beats an increment in the same cycle; software should stop
  // the timer before writing an asynchronously running count.
  always_comb begin
    inc = pre_tick;
    wrap = inc & ~wr_any & (cnt == `GST_CNT_MAX);
    if (wr_high && wr_low) begin
      next_cnt = {wr_data, wr_data}; // R1
    end else if (wr_high) begin
      next_cnt = {wr_data, cnt[7:0]}; // R1
    end else if (wr_low) begin
      next_cnt = {cnt[15:8], wr_data}; // R1
    end else if (inc) begin
      next_cnt = cnt + `GST_CNT_ONE;
    end else begin
      next_cnt = cnt;
    end
    // A wrap in the clear cycle keeps the flag set.
    next_overflow_flag = wrap | (overflow_flag & ~overflow_clear); // R19
    next_wake_pulse = wrap & sleep; // R15
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= `GST_CNT_RESET;
      overflow_flag <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      overflow_flag <= next_overflow_flag;
      wake_pulse <= next_wake_pulse;
    end
  end

  // The byte outputs are the live counter flops.
  always_comb begin
    count_high_byte = cnt[15:8];
    count_low_byte = cnt[7:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_write_high_byte: assert property (wr_high && !wr_low |=> count_high_byte == $past(wr_data)) // R1
    else $error("high byte write not taken");
  chk_off_holds_count: assert property (!cfg.timer_on && !wr_any |=> cnt == $past(cnt)) // R3
    else $error("counter moved while off");
  chk_gate_holds_count: assert property (cfg.timer_on && cfg.gate_enable // R18
    && (gate_level != cfg.gate_polarity) && !wr_any |=> cnt == $past(cnt))
    else $error("counter moved while gated off");
  chk_sys_rate_one: assert property (cfg.clock_select == `GST_CS_SYS && cfg.prescale_select == `GST_PS_DIV1 // R6
    && cfg.timer_on && !cfg.gate_enable && !sleep && !wr_any |=> cnt == $past(cnt) + `GST_CNT_ONE)
    else $error("system clock source missed a count");
  chk_instr_div_four: assert property (cfg.clock_select == `GST_CS_INSTR && instr_div != `GST_DIV_LAST // R2
    && !wr_any |=> cnt == $past(cnt))
    else $error("instruction clock counted off its cycle");
  chk_prescale_clear: assert property (wr_any |=> pre == `GST_PRE_RESET) // R10
    else $error("prescaler not cleared by write");
  chk_prescale_eight: assert property (cfg.prescale_select == `GST_PS_DIV8 && pre != `GST_MASK_DIV8 // R9
    && !wr_any |=> cnt == $past(cnt))
    else $error("divide by eight counted early");
  chk_arm_needs_fall: assert property (cfg.clock_select == `GST_CS_EXT && arm == GST_WAIT_LOW // R8
    && !wr_any |=> cnt == $past(cnt))
    else $error("counted before a falling edge");
  chk_sleep_sync_stop: assert property (sleep && !(cfg.clock_select == `GST_CS_EXT && cfg.sync_disable) // R15
    && !wr_any |=> cnt == $past(cnt))
    else $error("synchronous source counted in sleep");
  chk_overflow_sticky: assert property (overflow_flag && !overflow_clear |=> overflow_flag) // R19
    else $error("overflow flag dropped without clear");
  chk_wrap_sets_flag: assert property (wrap |=> overflow_flag && cnt == `GST_CNT_RESET) // R19
    else $error("wrap did not set overflow");
  chk_osc_go_runs: assert property (sec_osc_go |=> sec_osc_running) // R11
    else $error("oscillator go bit ignored");

  cov_overflow: cover property (wrap);
  cov_sleep_wake: cover property (wake_pulse);
  cov_ext_count: cover property (cfg.clock_select == `GST_CS_EXT && inc);
  cov_gate_hold: cover property (cfg.gate_enable && cfg.timer_on && (gate_level != cfg.gate_polarity));

endmodule

// *** sim/gst_clk_src.sv ***
// Stand-in for the external count source or the crystal on the oscillator input.
module gst_clk_src #(
  parameter int HALF = 5 // Cycles of clk_sys per half period.
) (
  // Clock and control.
  input wire logic clk_sys,
  input wire logic run,
  // Pin level and the count of rises made.
  output logic pin,
  output int rises
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0; // Half period counter.
  initial pin = 1'b0;
  initial rises = 0;
  ////////////////////////////////////////////////////////////////////////////
  // The source stands low between bursts; a burst that is stopped while high
  // still finishes its high phase, so no rise is ever cut short.
  always @(posedge clk_sys) begin
    #1;
    if (run || pin) begin
      if (cnt >= HALF - 1) begin
        cnt = 0;
        pin = ~pin;
        if (pin) begin
          rises++;
        end
      end else begin
        cnt++;
      end
    end else begin
      cnt = 0;
    end
  end
endmodule

// *** sim/testbench.sv ***
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

// Drives the timer through its plain ports and checks counts.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import gst_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  gst_cfg_t c = '0; // Configuration under test.
  logic [1:0] oth = 2'h0;
  logic go = 1'b0;
  logic [1:0] scs = 2'h0;
  logic sleep = 1'b0;
  logic wr_high = 1'b0;
  logic wr_low = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic ovf_clr = 1'b0;
  logic [3:0] gsrc = 4'h0; // Gate pin, match, cmp1, cmp2.
  logic run_p [2] = '{1'b0, 1'b0}; // Burst requests to both sources.
  logic pin_s [2];
  int rise_s [2];
  logic [7:0] hb;
  logic [7:0] lb;
  logic ovf;
  logic wake;
  logic osc_run;
  logic osc_out;
  int n_fail = 0;
  int num_checks = 0;
  int n_wake = 0;
  logic [15:0] e;
  ////////////////////////////////////////////////////////////////////////////
  always #4 clk_sys = ~clk_sys;
  gst_clk_src #(.HALF(5)) i_gst_clk_src_pin (.clk_sys(clk_sys), .run(run_p[0]), .pin(pin_s[0]), .rises(rise_s[0]));
  gst_clk_src #(.HALF(7)) i_gst_clk_src_osc (.clk_sys(clk_sys), .run(run_p[1]), .pin(pin_s[1]), .rises(rise_s[1]));
  gst_timer i_gst_timer (.clk_sys(clk_sys), .nrst(nrst), .cfg(c), .other_sec_osc_enable(oth), .sec_osc_go(go),
    .system_clock_select(scs), .sleep(sleep), .wr_high(wr_high), .wr_low(wr_low), .wr_data(wr_data),
    .overflow_clear(ovf_clr), .count_input_pin(pin_s[0]), .sec_osc_in_pin(pin_s[1]), .gate_pin(gsrc[0]),
    .gate_match(gsrc[1]), .gate_cmp1(gsrc[2]), .gate_cmp2(gsrc[3]), .count_high_byte(hb), .count_low_byte(lb),
    .overflow_flag(ovf), .wake_pulse(wake), .sec_osc_running(osc_run), .sec_osc_out_pin(osc_out));
  // The wake pulse lasts one cycle, so it is counted rather than sampled.
  always @(posedge clk_sys) begin
    if (wake === 1'b1) begin
      n_wake++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One-cycle byte write strobe, then one idle edge, so that two writes in a
  // row never lower and raise a strobe within one time step.
  task automatic wr(input logic h, input logic l, input logic [7:0] d);
    wr_high = h;
    wr_low = l;
    wr_data = d;
    tick(1);
    wr_high = 1'b0;
    wr_low = 1'b0;
    tick(1);
  endtask
  // Open the timer for exactly n clock edges; the tail lets the last count land.
  task automatic span(input int n, input logic on);
    c.timer_on = on;
    tick(n);
    c.timer_on = 1'b0;
    tick(2);
  endtask
  // Burst of k rises from one source, loaded with a start value while the pin
  // is high, so the first counted rise must follow a fresh fall.
  task automatic ext(input int s, input int k, input logic [15:0] v);
    int r0;
    c.timer_on = 1'b1;
    run_p[s] = 1'b1;
    for (int i = 0; i < 40 && pin_s[s] !== 1'b1; i++) tick(1);
    tick(2);
    wr(1'b1, 1'b1, v[7:0]);
    wr(1'b1, 1'b0, v[15:8]);
    r0 = rise_s[s];
    for (int i = 0; i < 400 && rise_s[s] < r0 + k; i++) tick(1);
    run_p[s] = 1'b0;
    tick(14);
    c.timer_on = 1'b0;
    tick(2);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // The longest run is well under 6000 cycles; this margin only catches hangs.
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    tick(1);
    `CHK("reset count", 16'h0000, {hb, lb})
    `CHK("reset flag", 1'b0, ovf)
    wr(1'b0, 1'b1, 8'h5a);
    wr(1'b1, 1'b0, 8'ha5);
    `CHK("byte writes", 16'ha55a, {hb, lb})
    $display("test byte writes done");
    // System clock gives one count per cycle, instruction clock one per four.
    for (int ps = 0; ps < 4; ps++) begin
      for (int s = 0; s < 2; s++) begin
        wr(1'b1, 1'b1, 8'h00);
        c.clock_select = s[1:0];
        c.prescale_select = ps[1:0];
        span(32, 1'b1);
        e = 16'(32 / (s == 1 ? 1 : 4) / (1 << ps));
        `CHK("prescaled count", e, {hb, lb})
      end
    end
    // A write drops the partial prescale count: 5 + 7 events make no count.
    c.clock_select = `GST_CS_SYS;
    span(5, 1'b1);
    wr(1'b1, 1'b1, 8'h10);
    span(7, 1'b1);
    `CHK("prescaler cleared", 16'h1010, {hb, lb})
    c.prescale_select = `GST_PS_DIV1;
    c.clock_select = 2'h3;
    span(16, 1'b1);
    `CHK("no clock", 16'h1010, {hb, lb})
    $display("test clock sources done");
    // Only the chosen gate source sits at lvl; the others show the opposite.
    c.clock_select = `GST_CS_SYS;
    c.gate_enable = 1'b1;
    for (int g = 0; g < 4; g++) begin
      for (int m = 0; m < 4; m++) begin
        c.gate_select = g[1:0];
        c.gate_polarity = m[1];
        gsrc = m[0] ? (4'h1 << g) : ~(4'h1 << g);
        wr(1'b1, 1'b1, 8'h00);
        span(16, 1'b1);
        e = (m[0] == m[1]) ? 16'h0010 : 16'h0000;
        `CHK("gated count", e, {hb, lb})
      end
    end
    gsrc = 4'hf;
    c.gate_polarity = 1'b1;
    span(16, 1'b0);
    `CHK("timer off", 16'h0010, {hb, lb})
    c.gate_enable = 1'b0;
    $display("test gate done");
    // External pin through both input paths; crystal twice, as sync disable does not change its path.
    c.clock_select = `GST_CS_EXT;
    for (int m = 0; m < 4; m++) begin
      c.sync_disable = m[0];
      c.sec_osc_enable = m[1];
      // A crystal needs time to start, so the timer is only switched on later.
      tick(8);
      `CHK("osc request", m[1], osc_run)
      ext(m[1], 6, 16'h0100);
      `CHK("edge count", 16'h0106, {hb, lb})
    end
    c.sec_osc_enable = 1'b0;
    $display("test external source done");
    c.clock_select = `GST_CS_SYS;
    wr(1'b1, 1'b1, 8'hff);
    wr(1'b0, 1'b1, 8'hfe);
    span(2, 1'b1);
    `CHK("wrap value", 16'h0000, {hb, lb})
    `CHK("flag set", 1'b1, ovf)
    tick(5);
    `CHK("flag sticky", 1'b1, ovf)
    ovf_clr = 1'b1;
    tick(1);
    ovf_clr = 1'b0;
    tick(1);
    `CHK("flag cleared", 1'b0, ovf)
    sleep = 1'b1;
    span(8, 1'b1);
    `CHK("sleep holds sync", 16'h0000, {hb, lb})
    c.clock_select = `GST_CS_EXT;
    c.sync_disable = 1'b1;
    ext(0, 1, 16'hffff);
    `CHK("sleep wrap", 16'h0000, {hb, lb})
    `CHK("sleep flag", 1'b1, ovf)
    `CHK("wake pulses", 1, n_wake)
    $display("test overflow done");
    // Each request alone starts the oscillator; sleep is still on.
    for (int k = 0; k < 5; k++) begin
      oth = {k == 1, k == 0};
      go = (k == 2);
      scs = (k == 3) ? `GST_SCS_SEC_OSC : 2'h0;
      c.sec_osc_enable = (k == 4);
      tick(3);
      `CHK("osc running", 1'b1, osc_run)
      `CHK("osc amplifier on", 1'b1, osc_out)
      {oth, go, scs} = 5'h00;
      c.sec_osc_enable = 1'b0;
      tick(3);
      `CHK("osc stopped", 1'b0, osc_run)
      `CHK("osc amplifier off", 1'b0, osc_out)
    end
    $display("test oscillator done");
    end_sim();
  end
endmodule
